// *** sgwl_ctrl_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Serial controller model
// ----------------------------------------
module sgwl_ctrl_model (
	// Serial link to the loader
	output logic linkClock,
	output logic serialGainIn,
	output logic loadEnableN
);
	initial begin
		linkClock = 1'b0;
		serialGainIn = 1'b0;
		loadEnableN = 1'b1;
	end

	// One frame of n bits, oldest first; clock stands low before and after the frame
	task automatic send(input logic [15:0] bits, input int n);
		#3.7 loadEnableN = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serialGainIn = bits[i];
			#62.5 linkClock = 1'b1;
			#62.5 linkClock = 1'b0;
		end
		#62.5 loadEnableN = 1'b1;
		// Released data line shows the inverse, not a stale copy
		serialGainIn = ~serialGainIn;
	endtask

	// Clocks with load enable high; loader has to ignore these bits
	task automatic idle_clocks(input logic [7:0] bits);
		for (int i = 7; i >= 0; i--) begin
			serialGainIn = bits[i];
			#62.5 linkClock = 1'b1;
			#62.5 linkClock = 1'b0;
		end
		serialGainIn = ~serialGainIn;
	endtask
endmodule

// *** sgwl_loader.sv ***
`timescale 1ns/1ps
`include "sgwl_map.svh"

// How it works
// RULE1: Each gain setting arrives as an 8-bit serial word, most significant bit first, assembled in that order.
// RULE2: A rising link clock edge captures the data bit into a master stage, the next falling edge moves it to the slave.
// RULE3: A rising load enable commits the assembled word to the gain output and shuts off serial shifting.
// RULE4: A falling load enable freezes the gain output at its old value and opens the shift register to new bits.
// RULE5: Power-down low turns the output amplifier off and the reverse amplifier on, high does the opposite.
// RULE6: The controller holds load enable low for exactly eight link clocks per word, then raises it to commit; send holds it for n clocks (4, 8, 11).
// RULE7: When more than eight bits are clocked in, only the last eight are kept, the first of them ending at the MSB.

module sgwl_loader
	import sgwl_pkg::*;
#(
	parameter int WORD_W = `SGWL_WORD_W
) (
	// System clock, reset, enable
	input wire logic clock,
	input wire logic nrst,
	input wire logic clkEn,
	// Serial link
	input wire logic linkClock,
	input wire logic serialGainIn,
	input wire logic loadEnableN,
	// Amplifier control pin
	input wire logic ampOffN,
	// Gain bus
	output logic [WORD_W-1:0] gainWord,
	output logic gainUpdated,
	output logic loadOpen,
	// Amplifier enables
	output logic outAmpEn,
	output logic revAmpEn
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (WORD_W != `SGWL_WORD_W) begin : gBadWord
		$error("sgwl_loader: WORD_W must match the gain word width");
	end

	// ----------------------------------------
	// Edge decode
	// ----------------------------------------
	function automatic logic isRise(input logic prev, input logic cur);
		isRise = !prev && cur;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [WORD_W-1:0] shiftWord;
	logic [WORD_W-1:0] wordSync;
	logic enSync;
	logic ampSync;
	logic enPrev_reg;
	logic enRise;
	logic enFall;
	sgwl_state_e state_reg;
	sgwl_state_e state_next;
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	logic commitNow;
	logic [WORD_W-1:0] gain_reg;
	logic updated_reg;
	logic open_reg;
	logic outAmp_reg;
	logic revAmp_reg;

	// ----------------------------------------
	// Link domain shift register
	// ----------------------------------------
	// Runs on the controller clock; it may stop between frames, so
	// nothing here waits for an edge after the enable rises.
	sgwl_shift #(
		.STAGES(WORD_W)
	) uShift (
		.linkClock(linkClock),
		.nrst(nrst),
		.serialGainIn(serialGainIn),
		.loadEnableN(loadEnableN),
		.shiftWord(shiftWord)
	);

	// ----------------------------------------
	// Crossings into the system clock
	// ----------------------------------------
	// The word is still while loading is shut, so a plain two stage
	// bus sync is safe; the settle wait covers the skew between bits.
	sgwl_sync #(
		.WIDTH(WORD_W),
		.RST_VAL(`SGWL_SHIFT_RST)
	) uWordSync (
		.clock(clock),
		.nrst(nrst),
		.clkEn(clkEn),
		.asyncIn(shiftWord),
		.syncOut(wordSync)
	);

	sgwl_sync #(
		.WIDTH(1),
		.RST_VAL(`SGWL_ENABLE_RST)
	) uEnSync (
		.clock(clock),
		.nrst(nrst),
		.clkEn(clkEn),
		.asyncIn(loadEnableN),
		.syncOut(enSync)
	);

	sgwl_sync #(
		.WIDTH(1),
		.RST_VAL(`SGWL_AMPOFF_RST)
	) uAmpSync (
		.clock(clock),
		.nrst(nrst),
		.clkEn(clkEn),
		.asyncIn(ampOffN),
		.syncOut(ampSync)
	);

	// ----------------------------------------
	// Enable edges
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			enPrev_reg <= `SGWL_ENABLE_RST;
		end else if (clkEn) begin
			enPrev_reg <= enSync;
		end
	end

	assign enRise = isRise(enPrev_reg, enSync);
	assign enFall = isRise(!enPrev_reg, !enSync);

	// ----------------------------------------
	// Load sequence
	// ----------------------------------------
	assign commitNow = (state_reg == ST_COMMIT) && (settle_reg == 2'h0) && enSync;

	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		case (state_reg)
			ST_HOLD: begin
				if (enFall) begin // see RULE4
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (enRise) begin // see RULE3
					state_next = ST_COMMIT;
					settle_next = `SGWL_SETTLE_CYC;
				end
			end
			ST_COMMIT: begin
				// A new frame before the commit lands leaves the old gain in place
				if (!enSync) begin
					state_next = ST_LOAD;
				end else if (settle_reg == 2'h0) begin
					state_next = ST_HOLD;
				end else begin
					settle_next = settle_reg - 2'h1;
				end
			end
			default: begin
				state_next = ST_HOLD;
				settle_next = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_HOLD;
			settle_reg <= 2'h0;
		end else if (clkEn) begin
			state_reg <= state_next;
			settle_reg <= settle_next;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			open_reg <= 1'b0;
		end else if (clkEn) begin
			open_reg <= (state_next == ST_LOAD); // see RULE4
		end
	end

	// ----------------------------------------
	// Gain latch
	// ----------------------------------------
	// Only the commit step writes it, so a frame in flight never
	// disturbs the applied gain.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gain_reg <= `SGWL_GAIN_RST;
		end else if (clkEn && commitNow) begin
			gain_reg <= wordSync; // see RULE3 see RULE1
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			updated_reg <= 1'b0;
		end else if (clkEn) begin
			updated_reg <= commitNow;
		end
	end

	// ----------------------------------------
	// Amplifier control
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			outAmp_reg <= `SGWL_AMPOFF_RST;
			revAmp_reg <= !`SGWL_AMPOFF_RST;
		end else if (clkEn) begin
			outAmp_reg <= ampSync; // see RULE5
			revAmp_reg <= !ampSync; // see RULE5
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign gainWord = gain_reg;
	assign gainUpdated = updated_reg;
	assign loadOpen = open_reg;
	assign outAmpEn = outAmp_reg;
	assign revAmpEn = revAmp_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// A frozen clock enable stretches every sequence, so checks rest then.
	default clocking cbSys @(posedge clock);
	endclocking

	default disable iff (!nrst || !clkEn);

	sequence sqCloseFrame;
		(state_reg == ST_LOAD) && enRise;
	endsequence

	sequence sqSettle;
		enSync[*3];
	endsequence

	sequence sqOpenFrame;
		(state_reg == ST_HOLD) && enFall;
	endsequence

	property prCommit;
		sqCloseFrame ##1 sqSettle |=> gainUpdated && gainWord == $past(wordSync);
	endproperty

	property prOpen;
		sqOpenFrame |=> loadOpen ##1 $stable(gainWord);
	endproperty

	AST_COMMIT_ON_RISE: assert property (prCommit) // see RULE3
		else $error("gain word not committed after load enable rose");

	AST_OPEN_ON_FALL: assert property (prOpen) // see RULE4
		else $error("load did not open on load enable fall");

	AST_HOLD_WHILE_OPEN: assert property (loadOpen |=> $stable(gainWord)) // see RULE4
		else $error("gain word changed while a frame was loading");

	AST_CHANGE_ONLY_ON_COMMIT: assert property ( // see RULE3
		$changed(gainWord) |-> gainUpdated && $past(state_reg) == ST_COMMIT)
		else $error("gain word changed outside a commit");

	AST_WORD_STILL_IN_COMMIT: assert property ( // see RULE3
		(state_reg == ST_COMMIT) && $past(state_reg) == ST_COMMIT |-> $stable(wordSync))
		else $error("shift word moved while shifting was shut");

	AST_AMP_ON: assert property (ampSync |=> outAmpEn && !revAmpEn) // see RULE5
		else $error("output amplifier not enabled with power-down high");

	AST_AMP_OFF: assert property (!ampSync |=> !outAmpEn && revAmpEn) // see RULE5
		else $error("reverse amplifier not enabled with power-down low");

	AST_UPDATE_PULSE: assert property (gainUpdated |=> !gainUpdated) // see RULE3
		else $error("gain update pulse lasted more than one cycle");

	AST_CLOSE_SHUTS_OPEN: assert property (sqCloseFrame |=> !loadOpen) // see RULE3
		else $error("load stayed open after load enable rose");

	AST_HOLD_KEEPS_GAIN: assert property (state_reg == ST_HOLD |=> $stable(gainWord)) // see RULE4
		else $error("gain word changed while no frame was closing");

	// Frozen cycles keep settle and sync still, so one step back is enough
	AST_PULSE_AFTER_SETTLE: assert property ( // see RULE3
		gainUpdated |-> $past(settle_reg) == 2'h0 && $past(enSync))
		else $error("gain update without a settled closed frame");

endmodule

// *** sgwl_loader_tb.sv ***
`timescale 1ns/1ps

module sgwl_loader_tb;
	import sgwl_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock, nrst, clkEn, ampOffN;
	wire logic linkClock, serialGainIn, loadEnableN;
	logic [7:0] gainWord;
	logic gainUpdated, loadOpen, outAmpEn, revAmpEn;
	int miscompares = 0;
	int nTests = 0;
	int nPulses = 0;
	bit refBits[$] = '{0, 0, 0, 0, 0, 0, 0, 0};
	int refGain = 0;
	logic [31:0] rng = 32'h0000000D;

	sgwl_loader i_sgwl_loader (.clock(clock), .nrst(nrst), .clkEn(clkEn),
		.linkClock(linkClock), .serialGainIn(serialGainIn), .loadEnableN(loadEnableN),
		.ampOffN(ampOffN), .gainWord(gainWord), .gainUpdated(gainUpdated),
		.loadOpen(loadOpen), .outAmpEn(outAmpEn), .revAmpEn(revAmpEn));
	sgwl_ctrl_model i_sgwl_ctrl_model (.linkClock(linkClock),
		.serialGainIn(serialGainIn), .loadEnableN(loadEnableN));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) if (gainUpdated === 1'b1) nPulses++;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Frame plus reference update; short frames keep older bits (shift by count)
	task automatic frame(input logic [15:0] bits, input int n);
		int k;
		int old;
		old = refGain;
		fork
			i_sgwl_ctrl_model.send(bits, n);
			begin
				repeat (18) @(posedge clock);
				#1 chk("gainHeld", gainWord, 8'(old));
				chk("loadOpen", 8'(loadOpen), 8'h01);
			end
		join
		// Queue of the last eight bits; older bits stay when a frame is short
		for (int i = n - 1; i >= 0; i--) begin
			refBits.push_back(bits[i]);
			void'(refBits.pop_front());
		end
		refGain = 0;
		for (int j = 0; j < 8; j++) refGain = (refGain << 1) | refBits[j];
		k = 0;
		while (gainUpdated !== 1'b1 && k < 20) begin
			@(posedge clock);
			#1 k++;
		end
		chk("commitSeen", 8'(k < 20), 8'h01);
		chk("gainWord", gainWord, 8'(refGain));
		@(posedge clock);
		#1 chk("pulseLen", 8'(gainUpdated), 8'h00);
		chk("loadClosed", 8'(loadOpen), 8'h00);
		repeat (10) @(posedge clock);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int p;
		nrst = 1'b0;
		clkEn = 1'b1;
		ampOffN = 1'b1;
		repeat (4) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (6) @(posedge clock);
		#1 chk("rstGain", gainWord, 8'h00);
		chk("rstOutAmp", 8'(outAmpEn), 8'h01);
		$display("test reset done");
		frame(16'h00FF, 8);
		frame(16'h0000, 8);
		for (int t = 0; t < 4; t++) begin
			rng = xorshift(rng);
			frame({8'h00, rng[7:0]}, 8);
		end
		$display("test frames done");
		// Over-long frame keeps the last eight bits
		rng = xorshift(rng);
		frame({5'h00, rng[10:0]}, 11);
		$display("test long frame done");
		// Bits clocked with enable high must not enter or commit
		p = nPulses;
		rng = xorshift(rng);
		i_sgwl_ctrl_model.idle_clocks(rng[7:0]);
		repeat (10) @(posedge clock);
		#1 chk("idleGain", gainWord, 8'(refGain));
		chk("idlePulse", 8'(nPulses - p), 8'h00);
		rng = xorshift(rng);
		frame({12'h000, rng[3:0]}, 4);
		$display("test idle clocks done");
		for (int t = 0; t < 6; t++) begin
			rng = xorshift(rng);
			@(posedge clock);
			#1 ampOffN = (t < 2) ? t[0] : rng[0];
			repeat (6) @(posedge clock);
			#1 chk("outAmp", 8'(outAmpEn), 8'(ampOffN));
			chk("revAmp", 8'(revAmpEn), 8'(!ampOffN));
		end
		$display("test amplifier done");
		// Frozen clock enable holds the outputs, then they catch up
		@(posedge clock);
		#1 clkEn = 1'b0;
		ampOffN = !ampOffN;
		repeat (6) @(posedge clock);
		#1 chk("frozenAmp", 8'(outAmpEn), 8'(!ampOffN));
		clkEn = 1'b1;
		repeat (6) @(posedge clock);
		#1 chk("thawedAmp", 8'(outAmpEn), 8'(ampOffN));
		chk("thawedRev", 8'(revAmpEn), 8'(!ampOffN));
		$display("test clock enable done");
		// Reset in mid-run clears the gain and the shift stages
		@(posedge clock);
		#1 nrst = 1'b0;
		repeat (4) @(posedge clock);
		#1 chk("midRstGain", gainWord, 8'h00);
		nrst = 1'b1;
		refBits = '{0, 0, 0, 0, 0, 0, 0, 0};
		refGain = 0;
		repeat (6) @(posedge clock);
		rng = xorshift(rng);
		frame({12'h000, rng[3:0]}, 4);
		$display("test mid reset done");
		stop_test();
	end

	// Whole run is about 16 us; six times that means a hang
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
endmodule

// *** sgwl_map.svh ***
`ifndef SGWL_MAP_SVH
`define SGWL_MAP_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define SGWL_WORD_W 8
`define SGWL_WORD_MSB 7
`define SGWL_WORD_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SGWL_GAIN_RST 8'h00
`define SGWL_SHIFT_RST 8'h00
`define SGWL_AMPOFF_RST 1'b1
`define SGWL_ENABLE_RST 1'b1

// ----------------------------------------
// Timing counts, system clock cycles
// ----------------------------------------
`define SGWL_SYNC_STAGES 2
`define SGWL_SETTLE_CYC 2'h2

`endif

// *** sgwl_pkg.sv ***
`include "sgwl_map.svh"

package sgwl_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [`SGWL_WORD_MSB:`SGWL_WORD_LSB] sgwl_word_t;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_LOAD = 3'b010,
		ST_COMMIT = 3'b100
	} sgwl_state_e;

endpackage

// *** sgwl_shift.sv ***
`timescale 1ns/1ps
`include "sgwl_map.svh"

module sgwl_shift
	import sgwl_pkg::*;
#(
	parameter int STAGES = `SGWL_WORD_W
) (
	// Link clock and reset
	input wire logic linkClock,
	input wire logic nrst,
	// Serial link
	input wire logic serialGainIn,
	input wire logic loadEnableN,
	// Assembled word
	output logic [STAGES-1:0] shiftWord
);

	// ----------------------------------------
	// Master-slave stages
	// ----------------------------------------
	logic [STAGES-1:0] master_reg;
	logic [STAGES-1:0] slave_reg;

	if (STAGES != `SGWL_WORD_W) begin : gBadStages
		$error("sgwl_shift: STAGES must match the gain word width");
	end

	// Stage 0 takes the pin, so the first bit walks up to the MSB
	for (genvar i = 0; i < STAGES; i++) begin : gStage
		always_ff @(posedge linkClock or negedge nrst) begin
			if (!nrst) begin
				master_reg[i] <= 1'b0;
			end else if (!loadEnableN) begin // see RULE2 see RULE3 see RULE4
				master_reg[i] <= (i == 0) ? serialGainIn : slave_reg[(i == 0) ? 0 : i-1]; // see RULE1
			end
		end

		// Slave copy is harmless while shifting is shut: master is still
		always_ff @(negedge linkClock or negedge nrst) begin
			if (!nrst) begin
				slave_reg[i] <= 1'b0;
			end else begin
				slave_reg[i] <= master_reg[i]; // see RULE2
			end
		end
	end

	assign shiftWord = slave_reg; // see RULE7

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_LAST_EIGHT_MSB_FIRST: assert property (@(posedge linkClock) disable iff (!nrst) // see RULE7
		(!loadEnableN)[*8] ##1 1'b1 |-> shiftWord[0] == $past(serialGainIn)
			&& shiftWord[STAGES-1] == $past(serialGainIn, 8))
		else $error("shift word does not hold the last eight bits MSB first");

	AST_SHIFT_SHUT: assert property (@(posedge linkClock) disable iff (!nrst) // see RULE3
		loadEnableN |=> $stable(master_reg))
		else $error("master stage moved while loading was shut");

	AST_SLAVE_TRACKS: assert property (@(posedge linkClock) disable iff (!nrst) // see RULE2
		slave_reg == master_reg)
		else $error("slave stage missed the falling edge copy");

endmodule

// *** sgwl_sync.sv ***
`timescale 1ns/1ps
`include "sgwl_map.svh"

module sgwl_sync
	import sgwl_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic clkEn,
	// Data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// ----------------------------------------
	// Two stages, first one read by the second only
	// ----------------------------------------
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	if (WIDTH < 1) begin : gBadWidth
		$error("sgwl_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else if (clkEn) begin
			meta_reg <= asyncIn;
			sync_reg <= meta_reg;
		end
	end

	assign syncOut = sync_reg;

endmodule
